/* File: rtl/ledsc_top.sv */
// Linear motor direction, encoder polarity and resolution scaling with AHB-Lite registers
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Linear motor operation is on only while the second digit of the mode select holds 4.
// - Direction select 0 maps increasing commands to positive travel, 1 swaps both mappings.
// - Polarity digit 0 counts encoder up-steps upward, 1 counts them downward.
// - Reported speed is positive for positive travel when polarity matches the encoder, else negative.
// - Resolution in micrometres per count is numerator over denominator and scales the reported speed, not the position count.
// - New numerator and denominator take effect only after the next reset, old ones stay until then.
// - A bad resolution ratio raises the pole or resolution alarm during positioning or pole detection.
// - A pole detection failure is reported as the pole detection error alarm.
module ledsc_top
   import ledsc_pkg::*;
#(
   parameter int PERIOD_CYC = CTRL_PERIOD_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hwdata_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        enc_up_i,
   input  wire logic        enc_dn_i,
   input  wire logic        pole_detect_active_i,
   input  wire logic        pole_detect_fail_i,
   output logic             linear_mode_o,
   output logic             motor_step_pos_o,
   output logic             motor_step_neg_o,
   output logic             alarm_o,
   output logic [7:0]       alarm_code_o
);
   localparam int PW = $clog2(PERIOD_CYC);
   localparam logic [PW-1:0] PER_LAST = PW'(PERIOD_CYC - 1);

   // Parameter store survives reset, modelling non-volatile settings
   logic [15:0] num_store_ff = RES_NUM_RST;
   logic [15:0] den_store_ff = RES_DEN_RST;
   logic [15:0] nxt_num_store, nxt_den_store;

   logic [15:0] mode_ff,   nxt_mode;
   logic        dir_ff,    nxt_dir;
   logic [15:0] pol_ff,    nxt_pol;
   logic [15:0] num_act_ff, den_act_ff;
   logic        al_pole_ff, nxt_al_pole;
   logic        al_res_ff,  nxt_al_res;
   logic [31:0] pos_ff,    nxt_pos;
   logic [31:0] pos_prev_ff, nxt_pos_prev;
   logic [31:0] speed_ff,  nxt_speed;
   logic        sign_ff,   nxt_sign;
   logic [PW-1:0] per_ff,  nxt_per;
   logic        step_pos_ff, nxt_step_pos;
   logic        step_neg_ff, nxt_step_neg;
   logic [31:0] rdata_ff,  nxt_rdata;
   logic        wr_pend_ff, nxt_wr_pend;
   logic [7:0]  wr_addr_ff, nxt_wr_addr;
   logic [2:0]  up_sync_ff, dn_sync_ff;
   logic [1:0]  pd_act_ff, pd_fail_ff;

   logic        linear;
   logic        pol_inv;
   logic        ratio_bad;
   logic        up_evt, dn_evt;
   logic        addr_ok;
   logic [31:0] delta;
   logic [31:0] delta_mag;
   logic        div_start, div_done, div_busy;
   logic [47:0] div_quot;
   logic [47:0] dividend;

   assign linear    = (mode_ff[MODE_DIGIT_LSB +: 4] == MODE_LINEAR);
   assign pol_inv   = pol_ff[POL_DIGIT_LSB];
   assign ratio_bad = (num_act_ff == 16'h0000) || (den_act_ff == 16'h0000);
   assign up_evt    = up_sync_ff[1] && !up_sync_ff[2];
   assign dn_evt    = dn_sync_ff[1] && !dn_sync_ff[2];
   assign addr_ok   = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
   assign delta     = pos_ff - pos_prev_ff;
   assign delta_mag = delta[31] ? (32'h0 - delta) : delta;
   assign div_start = (per_ff == PER_LAST);
   assign dividend  = 48'(delta_mag) * 48'(num_act_ff);

   ledsc_div #(
      .W  (48),
      .DW (16)
   ) u_div (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .start_i    (div_start),
      .dividend_i (dividend),
      .divisor_i  (den_act_ff),
      .busy_o     (div_busy),
      .done_o     (div_done),
      .quot_o     (div_quot)
   );

   always_comb begin
      nxt_mode      = mode_ff;
      nxt_dir       = dir_ff;
      nxt_pol       = pol_ff;
      nxt_num_store = num_store_ff;
      nxt_den_store = den_store_ff;
      nxt_al_pole   = al_pole_ff;
      nxt_al_res    = al_res_ff;
      nxt_pos       = pos_ff;
      nxt_pos_prev  = pos_prev_ff;
      nxt_speed     = speed_ff;
      nxt_sign      = sign_ff;
      nxt_step_pos  = 1'b0;
      nxt_step_neg  = 1'b0;
      nxt_rdata     = rdata_ff;
      nxt_wr_pend   = 1'b0;
      nxt_wr_addr   = wr_addr_ff;
      nxt_per       = (per_ff == PER_LAST) ? '0 : per_ff + PW'(1);

      // Polarity-corrected feedback count
      if (up_evt && !dn_evt) begin
         nxt_pos = pol_inv ? pos_ff - 32'h1 : pos_ff + 32'h1;
      end else if (dn_evt && !up_evt) begin
         nxt_pos = pol_inv ? pos_ff + 32'h1 : pos_ff - 32'h1;
      end

      // Sample count change once per control period
      if (div_start) begin
         nxt_pos_prev = pos_ff;
         nxt_sign     = delta[31];
      end
      if (div_done) begin
         nxt_speed = sign_ff ? (32'h0 - div_quot[31:0]) : div_quot[31:0];
      end

      // Register writes in the data phase
      if (wr_pend_ff) begin
         unique case (wr_addr_ff)
            OFF_MODE:    nxt_mode      = hwdata_i[15:0];
            OFF_DIR:     nxt_dir       = hwdata_i[0];
            OFF_POL:     nxt_pol       = hwdata_i[15:0];
            OFF_RES_NUM: nxt_num_store = hwdata_i[15:0];
            OFF_RES_DEN: nxt_den_store = hwdata_i[15:0];
            OFF_STATUS: begin
               if (hwdata_i[ST_AL_POLE]) nxt_al_pole = 1'b0;
               if (hwdata_i[ST_AL_RES])  nxt_al_res  = 1'b0;
            end
            OFF_CMD: begin
               // Commands move the motor only in linear operation
               if (linear && (hwdata_i[CMD_INC] != hwdata_i[CMD_DEC])) begin
                  nxt_step_pos = hwdata_i[CMD_INC] ^ dir_ff;
                  nxt_step_neg = hwdata_i[CMD_DEC] ^ dir_ff;
               end
            end
            default: ;
         endcase
      end

      // Alarms: a set in the same cycle beats the software clear
      if (pd_fail_ff[1] || (pd_act_ff[1] && ratio_bad)) begin
         nxt_al_pole = 1'b1;
      end
      if ((nxt_step_pos || nxt_step_neg) && ratio_bad) begin
         nxt_al_res = 1'b1;
      end

      // Address phase: latch write target or fetch read data
      if (addr_ok) begin
         nxt_wr_pend = hwrite_i;
         nxt_wr_addr = haddr_i[7:0];
         if (!hwrite_i) begin
            unique case (haddr_i[7:0])
               OFF_MODE:     nxt_rdata = {16'h0, mode_ff};
               OFF_DIR:      nxt_rdata = {31'h0, dir_ff};
               OFF_POL:      nxt_rdata = {16'h0, pol_ff};
               OFF_RES_NUM:  nxt_rdata = {16'h0, num_store_ff};
               OFF_RES_DEN:  nxt_rdata = {16'h0, den_store_ff};
               OFF_RES_ACT:  nxt_rdata = {den_act_ff, num_act_ff};
               OFF_STATUS:   nxt_rdata = {29'h0, al_res_ff, al_pole_ff, linear};
               OFF_POSITION: nxt_rdata = pos_ff;
               OFF_SPEED:    nxt_rdata = speed_ff;
               default:      nxt_rdata = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      // Store is deliberately outside reset so settings outlast it
      num_store_ff <= nxt_num_store;
      den_store_ff <= nxt_den_store;
      up_sync_ff   <= {up_sync_ff[1:0], enc_up_i};
      dn_sync_ff   <= {dn_sync_ff[1:0], enc_dn_i};
      pd_act_ff    <= {pd_act_ff[0], pole_detect_active_i};
      pd_fail_ff   <= {pd_fail_ff[0], pole_detect_fail_i};
      if (reset_i) begin
         num_act_ff  <= num_store_ff;
         den_act_ff  <= den_store_ff;
         mode_ff     <= MODE_RST;
         dir_ff      <= 1'b0;
         pol_ff      <= POL_RST;
         al_pole_ff  <= 1'b0;
         al_res_ff   <= 1'b0;
         pos_ff      <= 32'h0;
         pos_prev_ff <= 32'h0;
         speed_ff    <= 32'h0;
         sign_ff     <= 1'b0;
         per_ff      <= '0;
         step_pos_ff <= 1'b0;
         step_neg_ff <= 1'b0;
         rdata_ff    <= 32'h0;
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= 8'h00;
      end else begin
         mode_ff     <= nxt_mode;
         dir_ff      <= nxt_dir;
         pol_ff      <= nxt_pol;
         al_pole_ff  <= nxt_al_pole;
         al_res_ff   <= nxt_al_res;
         pos_ff      <= nxt_pos;
         pos_prev_ff <= nxt_pos_prev;
         speed_ff    <= nxt_speed;
         sign_ff     <= nxt_sign;
         per_ff      <= nxt_per;
         step_pos_ff <= nxt_step_pos;
         step_neg_ff <= nxt_step_neg;
         rdata_ff    <= nxt_rdata;
         wr_pend_ff  <= nxt_wr_pend;
         wr_addr_ff  <= nxt_wr_addr;
      end
   end

   assign hrdata_o         = rdata_ff;
   assign hreadyout_o      = 1'b1;
   assign hresp_o          = 1'b0;
   assign linear_mode_o    = linear;
   assign motor_step_pos_o = step_pos_ff;
   assign motor_step_neg_o = step_neg_ff;
   assign alarm_o          = al_pole_ff || al_res_ff;
   assign alarm_code_o     = al_pole_ff ? ALM_POLE : (al_res_ff ? ALM_RES : ALM_NONE);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_cmd_write(logic [1:0] bits);
      wr_pend_ff && wr_addr_ff == OFF_CMD && hwdata_i[1:0] == bits && linear;
   endsequence

   a_inc_dir_map: assert property (s_cmd_write(2'b01) |=> (motor_step_pos_o != $past(dir_ff)))
      else $error("increasing command mapped to wrong direction");
   a_dec_dir_map: assert property (s_cmd_write(2'b10) |=> (motor_step_neg_o != $past(dir_ff)))
      else $error("decreasing command mapped to wrong direction");
   a_step_linear: assert property ((motor_step_pos_o || motor_step_neg_o) |-> $past(linear))
      else $error("motor stepped outside linear operation");
   a_pol_count_up: assert property ((up_evt && !dn_evt && !pol_inv) |=> pos_ff == $past(pos_ff) + 32'h1)
      else $error("encoder up step not counted upward");
   a_pol_count_inv: assert property ((up_evt && !dn_evt && pol_inv) |=> pos_ff == $past(pos_ff) - 32'h1)
      else $error("inverted polarity not counted downward");
   a_act_ratio_hold: assert property (##1 $stable(num_act_ff) && $stable(den_act_ff))
      else $error("active ratio changed without reset");
   a_speed_update: assert property (div_start |-> ##49 div_done)
      else $error("speed not updated within period");
   a_speed_sign: assert property ((div_done && sign_ff && div_quot[31:0] != 32'h0) |=> speed_ff[31])
      else $error("negative travel gave non-negative speed");
   a_pole_alarm: assert property (pd_fail_ff[1] |=> alarm_code_o == ALM_POLE && alarm_o)
      else $error("pole detection failure not reported");
   a_res_alarm: assert property (((nxt_step_pos || nxt_step_neg) && ratio_bad) |=> al_res_ff)
      else $error("bad ratio during positioning not flagged");
endmodule

/* File: rtl/ledsc_pkg.sv */
// Register map, field layout and timing constants for the linear encoder direction/scaling block
package ledsc_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFF_MODE      = 8'h00;
   localparam logic [7:0]  OFF_DIR       = 8'h04;
   localparam logic [7:0]  OFF_POL       = 8'h08;
   localparam logic [7:0]  OFF_RES_NUM   = 8'h0C;
   localparam logic [7:0]  OFF_RES_DEN   = 8'h10;
   localparam logic [7:0]  OFF_RES_ACT   = 8'h14;
   localparam logic [7:0]  OFF_STATUS    = 8'h18;
   localparam logic [7:0]  OFF_POSITION  = 8'h1C;
   localparam logic [7:0]  OFF_SPEED     = 8'h20;
   localparam logic [7:0]  OFF_CMD       = 8'h24;
   // Field positions
   localparam int          MODE_DIGIT_LSB = 4;
   localparam logic [3:0]  MODE_LINEAR    = 4'h4;
   localparam int          POL_DIGIT_LSB  = 0;
   localparam int          ST_LINEAR      = 0;
   localparam int          ST_AL_POLE     = 1;
   localparam int          ST_AL_RES      = 2;
   localparam int          CMD_INC        = 0;
   localparam int          CMD_DEC        = 1;
   // Reset values
   localparam logic [15:0] MODE_RST      = 16'h0000;
   localparam logic [15:0] POL_RST       = 16'h0000;
   localparam logic [15:0] RES_NUM_RST   = 16'h0001;
   localparam logic [15:0] RES_DEN_RST   = 16'h0001;
   // Alarm display codes
   localparam logic [7:0]  ALM_NONE      = 8'h00;
   localparam logic [7:0]  ALM_POLE      = 8'h27;
   localparam logic [7:0]  ALM_RES       = 8'h42;
   // Speed control period
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          CTRL_PERIOD_NS = 1000000;
   localparam int          CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
endpackage

/* File: rtl/ledsc_div.sv */
// Sequential restoring divider used for count-to-distance scaling
`timescale 1ns/1ps
module ledsc_div #(
   parameter int W  = 48,
   parameter int DW = 16
) (
   input  wire logic          core_clk_i,
   input  wire logic          reset_i,
   input  wire logic          start_i,
   input  wire logic [W-1:0]  dividend_i,
   input  wire logic [DW-1:0] divisor_i,
   output logic               busy_o,
   output logic               done_o,
   output logic [W-1:0]       quot_o
);
   localparam int CW = $clog2(W + 1);
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);
   localparam logic [CW-1:0] CNT_FULL = CW'(W);

   logic [DW:0]   rem_ff,  nxt_rem;
   logic [W-1:0]  quo_ff,  nxt_quo;
   logic [DW-1:0] dsr_ff,  nxt_dsr;
   logic [CW-1:0] cnt_ff,  nxt_cnt;
   logic          busy_ff, nxt_busy;
   logic          done_ff, nxt_done;
   logic [DW:0]   shifted;

   always_comb begin
      nxt_rem  = rem_ff;
      nxt_quo  = quo_ff;
      nxt_dsr  = dsr_ff;
      nxt_cnt  = cnt_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      shifted  = {rem_ff[DW-1:0], quo_ff[W-1]};
      if (start_i && !busy_ff) begin
         nxt_rem  = '0;
         nxt_quo  = dividend_i;
         nxt_dsr  = divisor_i;
         nxt_cnt  = CNT_FULL;
         nxt_busy = 1'b1;
      end else if (busy_ff) begin
         // Zero divisor yields all ones; the resolution alarm covers that case
         if (shifted >= {1'b0, dsr_ff}) begin
            nxt_rem = shifted - {1'b0, dsr_ff};
            nxt_quo = {quo_ff[W-2:0], 1'b1};
         end else begin
            nxt_rem = shifted;
            nxt_quo = {quo_ff[W-2:0], 1'b0};
         end
         nxt_cnt = cnt_ff - CNT_ONE;
         if (cnt_ff == CNT_ONE) begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rem_ff  <= '0;
         quo_ff  <= '0;
         dsr_ff  <= '0;
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         rem_ff  <= nxt_rem;
         quo_ff  <= nxt_quo;
         dsr_ff  <= nxt_dsr;
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   assign busy_o = busy_ff;
   assign done_o = done_ff;
   assign quot_o = quo_ff;
endmodule

/* File: dv/ledsc_motor_model.sv */
// Behavioural linear motor with incremental encoder and main power sequencing
`timescale 1ns/1ps
module ledsc_motor_model (
   input  wire logic core_clk_i,
   input  wire logic motor_step_pos_i,
   input  wire logic motor_step_neg_i,
   input  wire logic manual_move_i,
   input  wire logic enc_rev_i,
   input  wire logic alarm_i,
   output logic      enc_up_o,
   output logic      enc_dn_o,
   output logic      main_power_o
);
   logic [1:0] busy_ff = 2'h0;
   logic       neg;
   initial begin
      enc_up_o = 1'b0;
      enc_dn_o = 1'b0;
      main_power_o = 1'b1;
   end
   // Two cycles high, two low: slow enough for the pin synchronisers
   always @(posedge core_clk_i) begin
      neg = motor_step_neg_i & ~motor_step_pos_i;
      if (busy_ff != 2'h0) busy_ff <= busy_ff - 2'h1;
      if (busy_ff == 2'h2) begin
         enc_up_o <= 1'b0;
         enc_dn_o <= 1'b0;
      end
      // Steps arriving while busy are lost, as on a real scale
      if (busy_ff == 2'h0 && (motor_step_pos_i || neg || manual_move_i)) begin
         enc_up_o <= ~(neg ^ enc_rev_i);
         enc_dn_o <= neg ^ enc_rev_i;
         busy_ff  <= 2'h3;
      end
      // Power stays off until the model is rebuilt
      if (alarm_i) main_power_o <= 1'b0;
   end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the linear encoder direction and scaling block
`timescale 1ns/1ps
module tb_top;
   import ledsc_pkg::*;
   localparam int P = 64;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        pd_act = 1'b0;
   logic        pd_fail = 1'b0;
   logic        manual = 1'b0;
   logic        enc_rev = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, enc_up, enc_dn, lin, stp_pos, stp_neg, alarm, pwr;
   logic [7:0]  alarm_code;
   logic [31:0] rd;
   logic [15:0] exp_pos = 16'h0;
   int          n_errors = 0;
   int          check_count = 0;
   int          cycles = 0;

   always #20 core_clk = ~core_clk;

   ledsc_top #(.PERIOD_CYC(P)) dut (
      .core_clk_i(core_clk), .reset_i(reset), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .enc_up_i(enc_up), .enc_dn_i(enc_dn),
      .pole_detect_active_i(pd_act), .pole_detect_fail_i(pd_fail), .linear_mode_o(lin),
      .motor_step_pos_o(stp_pos), .motor_step_neg_o(stp_neg), .alarm_o(alarm), .alarm_code_o(alarm_code));

   ledsc_motor_model model (
      .core_clk_i(core_clk), .motor_step_pos_i(stp_pos), .motor_step_neg_i(stp_neg),
      .manual_move_i(manual), .enc_rev_i(enc_rev), .alarm_i(alarm), .enc_up_o(enc_up),
      .enc_dn_o(enc_dn), .main_power_o(pwr));

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t %s: got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask

   // Signed readings compared on their low half only
   task automatic rds(input logic [7:0] a, input logic [15:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, e}, m);
   endtask

   task automatic do_reset();
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      exp_pos = 16'h0;
   endtask

   task automatic step(input logic [1:0] c, input logic ep, input logic en, input string m);
      wr(OFF_CMD, {30'h0, c});
      #1 chk(32'({stp_pos, stp_neg}), 32'({ep, en}), m);
      @(posedge core_clk);
      #1 chk(32'({stp_pos, stp_neg}), 32'h0, "step pulse too long");
      repeat (8) @(posedge core_clk);
   endtask

   // Wait past two clean control periods and the divider latency
   task automatic spd(input logic [15:0] e, input string m);
      repeat (3 * P + 80) @(posedge core_clk);
      rds(OFF_SPEED, e, m);
   endtask

   task automatic t_reset_values();
      rdc(OFF_MODE, 32'h0, "mode reset");
      rdc(OFF_POL, 32'h0, "polarity reset");
      rdc(OFF_RES_NUM, 32'h1, "numerator reset");
      rdc(OFF_RES_DEN, 32'h1, "denominator reset");
      rdc(OFF_RES_ACT, 32'h00010001, "active ratio reset");
      wr(8'h30, 32'hFFFFFFFF);
      rdc(8'h30, 32'h0, "unmapped read");
      chk(32'({hreadyout, hresp, lin, alarm}), 32'h8, "idle outputs");
      chk(32'(pwr), 32'h1, "main power on");
   endtask

   // A write lands on the edge the bus task returns at; look one edge later
   task automatic t_mode();
      wr(OFF_MODE, 32'h0004);
      @(posedge core_clk);
      chk(32'(lin), 32'h0, "wrong digit");
      step(2'b01, 1'b0, 1'b0, "move while not linear");
      wr(OFF_MODE, 32'h0F4F);
      @(posedge core_clk);
      chk(32'(lin), 32'h1, "linear digit");
      rdc(OFF_STATUS, 32'h1, "status linear");
   endtask

   task automatic t_direction();
      logic p;
      for (int d = 0; d < 2; d++) begin
         wr(OFF_DIR, 32'(d));
         for (int c = 1; c < 3; c++) begin
            p = (c == 1) ^ (d == 1);
            step(2'(c), p, !p, "travel direction");
            exp_pos = p ? exp_pos + 16'h1 : exp_pos - 16'h1;
            rds(OFF_POSITION, exp_pos, "position count");
         end
      end
      step(2'b11, 1'b0, 1'b0, "both commands");
   endtask

   task automatic t_polarity();
      wr(OFF_DIR, 32'h0);
      wr(OFF_POL, 32'h1);
      step(2'b01, 1'b1, 1'b0, "step polarity one");
      rds(OFF_POSITION, exp_pos - 16'h1, "up count reversed");
      @(posedge core_clk);
      enc_rev <= 1'b1;
      step(2'b01, 1'b1, 1'b0, "step reversed scale");
      rds(OFF_POSITION, exp_pos, "down count reversed");
      @(posedge core_clk);
      enc_rev <= 1'b0;
      wr(OFF_POL, 32'h0);
   endtask

   task automatic t_speed();
      @(posedge core_clk);
      manual <= 1'b1;
      spd(16'd16, "speed matched");
      wr(OFF_POL, 32'h1);
      spd(16'hFFF0, "speed mismatched");
      @(posedge core_clk);
      enc_rev <= 1'b1;
      spd(16'd16, "reversed scale matched");
      wr(OFF_POL, 32'h0);
      spd(16'hFFF0, "reversed scale mismatched");
      @(posedge core_clk);
      enc_rev <= 1'b0;
      wr(OFF_RES_NUM, 32'h3);
      wr(OFF_RES_DEN, 32'h2);
      rdc(OFF_RES_ACT, 32'h00010001, "ratio before reset");
      spd(16'd16, "old ratio kept");
      do_reset();
      rdc(OFF_RES_ACT, 32'h00020003, "ratio after reset");
      spd(16'd24, "scaled speed");
      @(posedge core_clk);
      manual <= 1'b0;
   endtask

   task automatic t_alarm();
      wr(OFF_RES_NUM, 32'h0);
      do_reset();
      wr(OFF_MODE, 32'h0040);
      step(2'b01, 1'b1, 1'b0, "step with zero ratio");
      chk(32'({alarm, alarm_code}), {23'h0, 1'b1, ALM_RES}, "resolution alarm");
      chk(32'(pwr), 32'h0, "main power removed");
      rdc(OFF_STATUS, 32'h5, "status resolution");
      pd_fail <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(32'(alarm_code), 32'(ALM_POLE), "pole alarm priority");
      pd_fail <= 1'b0;
      wr(OFF_STATUS, 32'h2);
      @(posedge core_clk);
      chk(32'(alarm_code), 32'(ALM_RES), "pole cleared");
      wr(OFF_STATUS, 32'h4);
      @(posedge core_clk);
      chk(32'({alarm, alarm_code}), 32'(ALM_NONE), "all cleared");
      pd_act <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(32'({alarm, alarm_code}), {23'h0, 1'b1, ALM_POLE}, "pole detect zero ratio");
      pd_act <= 1'b0;
      wr(OFF_STATUS, 32'h2);
      @(posedge core_clk);
      chk(32'(alarm), 32'h0, "pole alarm cleared");
      wr(OFF_RES_NUM, 32'h1);
      do_reset();
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      t_reset_values();
      t_mode();
      t_direction();
      t_polarity();
      t_speed();
      t_alarm();
      print_verdict();
   end
endmodule
